// >>> acp_alarm_bit.sv
`timescale 1ns/1ps
`default_nettype none
module acp_alarm_bit (
  // clock
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic cond,
  input wire logic latchMode,
  input wire logic clrPulse,
  // relay
  output logic flag
);
  // transient follows cond; latch holds, new cond wins over clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (latchMode) begin
      flag <= cond | (flag & ~clrPulse);
    end else begin
      flag <= cond;
    end
  end
endmodule
`default_nettype wire

// >>> acp_buf_mem.sv
`timescale 1ns/1ps
`default_nettype none
module acp_buf_mem #(
  parameter int DW = 20,
  parameter int DEPTH = 600,
  parameter int AW = 10
) (
  // clock
  input wire logic clk_sys,
  input wire logic rst,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] wAddr,
  input wire logic [DW-1:0] wData,
  // read port
  input wire logic [AW-1:0] rAddr,
  output logic [DW-1:0] rData
);
  logic [DW-1:0] mem [0:DEPTH-1];

  // sample store
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wAddr] <= wData;
    end
  end

  // registered read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rData <= '0;
    end else begin
      rData <= mem[rAddr];
    end
  end
endmodule
`default_nettype wire

// >>> acp_channel.sv
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - clip enable confines the output to the nominal span of the range.
// - unipolar with clipping saturates at 0 and 80000.
// - without clipping, limits are -20000..100000 or -100000..100000.
// - clipping only on high-resolution variant, off after reset.
// - deviation relay rising captures output as reference, reports zero.
// - while deviation relay on, result is output minus reference.
// - deviation relay falling stops the subtraction.
// - offset enable adds the signed offset to the output.
// - offset off and zero after reset; range per variant.
// - buffer stores the computation value, one entry per point.
// - buffer holds at most 600 entries.
// - total points 1..600 default 600, pre-trigger 0..599 default 200.
// - complete relay sets once configured point count is stored.
// - controller reads the points; complete then returns off.
// - transient alarms clear when input returns to normal.
// - latched alarms stay on after input returns to normal.
// - alarm-clear relay rising clears latched alarms of the channel.
// - five alarm relays, each off while channel is normal in transient mode.
module acp_channel #(
  parameter bit HI_RES = 1'b1,
  parameter int DEPTH = 600
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // converter side
  input wire logic convValid,
  input wire logic signed [19:0] convData,
  input wire logic [4:0] alarmCond,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // relay views
  output logic [4:0] alarmRelay,
  output logic bufComplete
);
  logic [3:0] ctrl_r;
  logic [3:0] relay_r;
  logic [3:0] relayPrev_r;
  logic signed [19:0] ofs_r;
  logic [9:0] total_r;
  logic [9:0] pre_r;
  logic [9:0] bufIdx_r;
  logic [9:0] rdCnt_r;
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic signed [19:0] outVal_r;
  logic signed [19:0] compVal_r;
  logic signed [19:0] devRef_r;
  logic devOn_r;
  acp_pkg::acp_bufst_t st_r;
  logic [9:0] wrPtr_r, postCnt_r, start_r;
  logic [19:0] memRd;

  // relay edges, software-written on this clock
  wire devRise = relay_r[acp_pkg::REL_DEV] & ~relayPrev_r[acp_pkg::REL_DEV];
  wire devFall = ~relay_r[acp_pkg::REL_DEV] & relayPrev_r[acp_pkg::REL_DEV];
  wire reqRise = relay_r[acp_pkg::REL_BUFREQ] & ~relayPrev_r[acp_pkg::REL_BUFREQ];
  wire trigRise = relay_r[acp_pkg::REL_BUFTRIG] & ~relayPrev_r[acp_pkg::REL_BUFTRIG];
  wire clrRise = relay_r[acp_pkg::REL_ALMCLR] & ~relayPrev_r[acp_pkg::REL_ALMCLR];

  // limits per range and clip
  wire clipOn = HI_RES & ctrl_r[acp_pkg::CTRL_CLIP];
  wire bip = ctrl_r[acp_pkg::CTRL_BIPOLAR];
  wire signed [19:0] loLim = clipOn ? (bip ? acp_pkg::NOM_BI_LO : acp_pkg::NOM_UNI_LO)
    : (bip ? acp_pkg::EXT_BI_LO : acp_pkg::EXT_UNI_LO);
  wire signed [19:0] hiLim = clipOn ? acp_pkg::NOM_HI : acp_pkg::EXT_HI;
  wire signed [19:0] outNxt = (convData < loLim) ? loLim : (convData > hiLim) ? hiLim : convData;
  wire signed [19:0] devSub = devOn_r ? devRef_r : 20'sh00000;
  wire signed [19:0] ofsAdd = ctrl_r[acp_pkg::CTRL_OFSEN] ? ofs_r : 20'sh00000;
  wire signed [19:0] compNxt = outNxt - devSub + ofsAdd;

  // value path, deviation reference
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outVal_r <= '0;
      compVal_r <= '0;
      devRef_r <= '0;
      devOn_r <= 1'b0;
    end else begin
      if (convValid) begin
        outVal_r <= outNxt;
      end
      if (devRise) begin
        devRef_r <= outVal_r;
        devOn_r <= 1'b1;
        compVal_r <= '0;
      end else begin
        if (devFall) begin
          devOn_r <= 1'b0;
        end
        if (convValid) begin
          compVal_r <= compNxt;
        end
      end
    end
  end

  // buffer pointer arithmetic
  wire bufWr = convValid & (st_r == acp_pkg::ACP_PRE || st_r == acp_pkg::ACP_POST);
  wire [9:0] ptrInc = (wrPtr_r == total_r - 10'h001) ? 10'h000 : wrPtr_r + 10'h001;
  wire [9:0] ptrNxt = bufWr ? ptrInc : wrPtr_r;
  wire [9:0] preEff = (pre_r >= total_r) ? total_r - 10'h001 : pre_r;
  wire [9:0] startNxt = (ptrNxt >= preEff) ? ptrNxt - preEff : ptrNxt + total_r - preEff;
  wire [10:0] rdSum = {1'b0, start_r} + {1'b0, bufIdx_r};
  wire [10:0] rdWrap = (rdSum >= {1'b0, total_r}) ? rdSum - {1'b0, total_r} : rdSum;
  // last post sample only counts while the request still stands
  wire postDone = (st_r == acp_pkg::ACP_POST) & convValid & (postCnt_r == 10'h001)
    & relay_r[acp_pkg::REL_BUFREQ];
  wire bufDataRd;
  wire readDone = bufComplete & bufDataRd & (rdCnt_r == total_r - 10'h001);

  // buffer sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= acp_pkg::ACP_IDLE;
      wrPtr_r <= '0;
      postCnt_r <= '0;
      start_r <= '0;
      bufComplete <= 1'b0;
    end else begin
      wrPtr_r <= ptrNxt;
      if (readDone) begin
        bufComplete <= 1'b0;
      end
      if (!relay_r[acp_pkg::REL_BUFREQ]) begin
        st_r <= acp_pkg::ACP_IDLE;
      end else begin
        case (st_r)
          acp_pkg::ACP_IDLE: begin
            if (reqRise) begin
              st_r <= acp_pkg::ACP_PRE;
              wrPtr_r <= '0;
              bufComplete <= 1'b0;
            end
          end
          acp_pkg::ACP_PRE: begin
            if (trigRise) begin
              start_r <= startNxt;
              postCnt_r <= total_r - preEff;
              st_r <= acp_pkg::ACP_POST;
            end
          end
          acp_pkg::ACP_POST: begin
            if (postDone) begin
              st_r <= acp_pkg::ACP_DONE;
              bufComplete <= 1'b1;
            end else if (convValid) begin
              postCnt_r <= postCnt_r - 10'h001;
            end
          end
          acp_pkg::ACP_DONE: begin
            if (trigRise) begin
              bufComplete <= 1'b0;
              start_r <= ptrNxt; // fresh capture, no stale pre-trigger part
              postCnt_r <= total_r;
              st_r <= acp_pkg::ACP_POST;
            end
          end
          default: st_r <= acp_pkg::ACP_IDLE;
        endcase
      end
    end
  end

  // sample store, computation values only
  acp_buf_mem #(.DW(20), .DEPTH(DEPTH), .AW(10)) uMem (
    .clk_sys(clk_sys),
    .rst(rst),
    .we(bufWr),
    .wAddr(wrPtr_r),
    .wData(compNxt),
    .rAddr(rdWrap[9:0]),
    .rData(memRd)
  );

  // five alarm relays
  genvar gi;
  for (gi = 0; gi < 5; gi++) begin : gAlarm
    acp_alarm_bit uAlm (
      .clk_sys(clk_sys),
      .rst(rst),
      .cond(alarmCond[gi]),
      .latchMode(ctrl_r[acp_pkg::CTRL_LATCH]),
      .clrPulse(clrRise),
      .flag(alarmRelay[gi])
    );
  end

  // bus write side
  wire doWrite = awHeld_r & wHeld_r;
  wire [31:0] bMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  wire [31:0] mCtrl = ({28'h0, ctrl_r} & ~bMask) | (wData_r & bMask);
  wire [31:0] mRelay = ({28'h0, relay_r} & ~bMask) | (wData_r & bMask);
  wire [31:0] mOfs = ({{12{ofs_r[19]}}, ofs_r} & ~bMask) | (wData_r & bMask);
  wire [31:0] mTotal = ({22'h0, total_r} & ~bMask) | (wData_r & bMask);
  wire [31:0] mPre = ({22'h0, pre_r} & ~bMask) | (wData_r & bMask);
  wire [31:0] mIdx = ({22'h0, bufIdx_r} & ~bMask) | (wData_r & bMask);
  wire signed [31:0] ofsW = mOfs;
  wire signed [31:0] ofsLim = HI_RES ? 32'(acp_pkg::OFS_LIM_HI) : 32'(acp_pkg::OFS_LIM_LO);
  wire signed [31:0] ofsClamp = (ofsW > ofsLim) ? ofsLim : (ofsW < -ofsLim) ? -ofsLim : ofsW;
  wire wHit = (awAddr_r == acp_pkg::OFS_CTRL) || (awAddr_r == acp_pkg::OFS_RELAY)
    || (awAddr_r == acp_pkg::OFS_OFFSET) || (awAddr_r == acp_pkg::OFS_TOTAL)
    || (awAddr_r == acp_pkg::OFS_PRE) || (awAddr_r == acp_pkg::OFS_BUFIDX);
  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;

  // address and data holding, response
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wHit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= acp_pkg::CTRL_RST;
      relay_r <= '0;
      relayPrev_r <= '0;
      ofs_r <= '0;
      total_r <= acp_pkg::TOTAL_RST;
      pre_r <= acp_pkg::PRE_RST;
      bufIdx_r <= '0;
      rdCnt_r <= '0;
    end else begin
      relayPrev_r <= relay_r;
      if (postDone) begin
        rdCnt_r <= '0;
      end else if (bufDataRd) begin
        rdCnt_r <= rdCnt_r + 10'h001;
      end
      if (doWrite && awAddr_r == acp_pkg::OFS_BUFIDX) begin
        bufIdx_r <= mIdx[9:0];
      end else if (postDone) begin
        bufIdx_r <= '0;
      end else if (bufDataRd) begin
        bufIdx_r <= bufIdx_r + 10'h001;
      end
      if (doWrite) begin
        case (awAddr_r)
          acp_pkg::OFS_CTRL: ctrl_r <= {mCtrl[3:1], mCtrl[0] & HI_RES};
          acp_pkg::OFS_RELAY: relay_r <= mRelay[3:0];
          acp_pkg::OFS_OFFSET: ofs_r <= ofsClamp[19:0];
          acp_pkg::OFS_TOTAL: total_r <= (mTotal[31:0] == 32'h0) ? 10'h001
            : (mTotal > {22'h0, acp_pkg::TOTAL_MAX}) ? acp_pkg::TOTAL_MAX : mTotal[9:0];
          acp_pkg::OFS_PRE: pre_r <= (mPre > {22'h0, acp_pkg::PRE_MAX}) ? acp_pkg::PRE_MAX
            : mPre[9:0];
          default: ;
        endcase
      end
    end
  end

  // bus read side
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire [7:0] arA = {s_axi_araddr[7:2], 2'b00};
  assign bufDataRd = arTake & (arA == acp_pkg::OFS_BUFDATA);
  wire [31:0] statusW = {25'h0, devOn_r, alarmRelay, bufComplete};
  wire rHit = (arA <= acp_pkg::OFS_BUFDATA);
  wire [31:0] rdMux = (arA == acp_pkg::OFS_CTRL) ? {28'h0, ctrl_r}
    : (arA == acp_pkg::OFS_RELAY) ? {28'h0, relay_r}
    : (arA == acp_pkg::OFS_OFFSET) ? {{12{ofs_r[19]}}, ofs_r}
    : (arA == acp_pkg::OFS_TOTAL) ? {22'h0, total_r}
    : (arA == acp_pkg::OFS_PRE) ? {22'h0, pre_r}
    : (arA == acp_pkg::OFS_STATUS) ? statusW
    : (arA == acp_pkg::OFS_COMP) ? {{12{compVal_r[19]}}, compVal_r}
    : (arA == acp_pkg::OFS_BUFIDX) ? {22'h0, bufIdx_r}
    : (arA == acp_pkg::OFS_BUFDATA) ? {{12{memRd[19]}}, memRd} : 32'h0;
  assign s_axi_arready = ~s_axi_rvalid;

  // read answer one cycle after address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rHit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  property p_devzero;
    @(posedge clk_sys) disable iff (rst) devRise |=> compVal_r == 20'sh00000;
  endproperty
  a_devzero: assert property (p_devzero) else $error("deviation start not zero");

  property p_devsub;
    @(posedge clk_sys) disable iff (rst)
      convValid && devOn_r && !devRise && !devFall && !ctrl_r[acp_pkg::CTRL_OFSEN]
      |=> compVal_r == $past(outNxt) - devRef_r;
  endproperty
  a_devsub: assert property (p_devsub) else $error("deviation not subtracted");

  property p_ofs;
    @(posedge clk_sys) disable iff (rst)
      convValid && !devOn_r && !devRise && ctrl_r[acp_pkg::CTRL_OFSEN]
      |=> compVal_r == $past(outNxt) + $past(ofs_r);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset not added");

  property p_clipuni;
    @(posedge clk_sys) disable iff (rst)
      convValid && clipOn && !bip |=> outVal_r >= 20'sh00000 && outVal_r <= 20'sh13880;
  endproperty
  a_clipuni: assert property (p_clipuni) else $error("unipolar clip out of span");

  property p_extlim;
    @(posedge clk_sys) disable iff (rst)
      convValid |=> outVal_r >= -20'sh186A0 && outVal_r <= 20'sh186A0;
  endproperty
  a_extlim: assert property (p_extlim) else $error("extended limit exceeded");

  property p_done;
    @(posedge clk_sys) disable iff (rst) postDone |=> bufComplete && st_r == acp_pkg::ACP_DONE;
  endproperty
  a_done: assert property (p_done) else $error("complete not raised");

  property p_retrig;
    @(posedge clk_sys) disable iff (rst)
      st_r == acp_pkg::ACP_DONE && relay_r[acp_pkg::REL_BUFREQ] && trigRise |=> !bufComplete;
  endproperty
  a_retrig: assert property (p_retrig) else $error("complete kept after retrigger");

  property p_transient;
    @(posedge clk_sys) disable iff (rst)
      !ctrl_r[acp_pkg::CTRL_LATCH] ##1 !ctrl_r[acp_pkg::CTRL_LATCH] |-> alarmRelay == $past(alarmCond);
  endproperty
  a_transient: assert property (p_transient) else $error("transient alarm mismatch");

  property p_latch;
    @(posedge clk_sys) disable iff (rst)
      ctrl_r[acp_pkg::CTRL_LATCH] && !clrRise |=> (alarmRelay & $past(alarmRelay)) == $past(alarmRelay);
  endproperty
  a_latch: assert property (p_latch) else $error("latched alarm dropped");
endmodule
`default_nettype wire

// >>> acp_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller model: axi4-lite master that sets relays and reads results
module acp_ctl_model (
  // clock
  input wire logic clk_sys,
  // write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero
  initial begin
    awaddr <= 8'h00;
    awvalid <= 1'b0;
    wdata <= 32'h0;
    wstrb <= 4'hF;
    wvalid <= 1'b0;
    bready <= 1'b0;
    araddr <= 8'h00;
    arvalid <= 1'b0;
    rready <= 1'b0;
  end

  // one write; relay raise and lower go through here too
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // one read; buffer points are fetched this way after completion
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// >>> acp_pkg.sv
`default_nettype none
package acp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RELAY = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_TOTAL = 8'h0C;
  localparam logic [7:0] OFS_PRE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_COMP = 8'h18;
  localparam logic [7:0] OFS_BUFIDX = 8'h1C;
  localparam logic [7:0] OFS_BUFDATA = 8'h20;
  // control bit positions
  localparam int CTRL_CLIP = 0;
  localparam int CTRL_OFSEN = 1;
  localparam int CTRL_LATCH = 2;
  localparam int CTRL_BIPOLAR = 3;
  // relay bit positions
  localparam int REL_DEV = 0;
  localparam int REL_BUFREQ = 1;
  localparam int REL_BUFTRIG = 2;
  localparam int REL_ALMCLR = 3;
  // status bit positions
  localparam int ST_DONE = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_DEVON = 6;
  // value limits, 20-bit signed
  localparam logic signed [19:0] NOM_HI = 20'sh13880; // 80000
  localparam logic signed [19:0] NOM_UNI_LO = 20'sh00000;
  localparam logic signed [19:0] NOM_BI_LO = -20'sh13880;
  localparam logic signed [19:0] EXT_HI = 20'sh186A0; // 100000
  localparam logic signed [19:0] EXT_UNI_LO = -20'sh04E20; // -20000
  localparam logic signed [19:0] EXT_BI_LO = -20'sh186A0;
  localparam logic signed [19:0] OFS_LIM_LO = 20'sh03FFF; // 16383
  localparam logic signed [19:0] OFS_LIM_HI = 20'sh14050; // 82000
  // reset values and write limits
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [9:0] TOTAL_RST = 10'h258; // 600
  localparam logic [9:0] PRE_RST = 10'h0C8; // 200
  localparam logic [9:0] TOTAL_MAX = 10'h258;
  localparam logic [9:0] PRE_MAX = 10'h257; // 599
  // buffer sequencer states
  typedef enum logic [3:0] {
    ACP_IDLE = 4'b0001,
    ACP_PRE = 4'b0010,
    ACP_POST = 4'b0100,
    ACP_DONE = 4'b1000
  } acp_bufst_t;
endpackage
`default_nettype wire

// >>> adc_channel_postprocess_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_channel_postprocess_bench;
  logic clk_sys, rst, convValid, bufComplete;
  logic signed [19:0] convData;
  logic [4:0] alarmCond, alarmRelay;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int n_fail = 0;
  int num_checks = 0;

  acp_channel uut (.clk_sys(clk_sys), .rst(rst), .convValid(convValid), .convData(convData),
    .alarmCond(alarmCond), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .alarmRelay(alarmRelay), .bufComplete(bufComplete));

  acp_ctl_model ctl (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // register write expecting an okay response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    ctl.wr(a, d, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    ctl.rd(a, d, r);
    chk($sformatf("reg %h", a), e, d);
  endtask

  // one conversion pulse
  task automatic cv(input logic signed [19:0] v);
    convValid <= 1'b1;
    convData <= v;
    @(posedge clk_sys);
    convValid <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic clipCase(input logic [31:0] c, input logic signed [19:0] v,
      input logic signed [19:0] e);
    wr(acp_pkg::OFS_CTRL, c);
    cv(v);
    rd(acp_pkg::OFS_COMP, 32'(e));
  endtask

  // request, two pre samples, trigger, three post samples
  task automatic capture;
    wr(acp_pkg::OFS_RELAY, 32'h2);
    cv(20'sh0000A);
    cv(20'sh0000B);
    wr(acp_pkg::OFS_RELAY, 32'h6);
    cyc(2);
    for (int i = 0; i < 3; i++) begin
      cv(20'(32'h14 + i));
      cyc(1);
      chk("bufComplete", {31'h0, i == 2}, {31'h0, bufComplete});
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    cyc(20000);
    n_fail++;
    complete_run;
  end

  initial begin
    rst <= 1'b1;
    convValid <= 1'b0;
    convData <= 20'sh00000;
    alarmCond <= 5'h00;
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    // reset values
    rd(acp_pkg::OFS_CTRL, 32'h0);
    rd(acp_pkg::OFS_OFFSET, 32'h0);
    rd(acp_pkg::OFS_TOTAL, 32'h258);
    rd(acp_pkg::OFS_PRE, 32'hC8);
    rd(acp_pkg::OFS_STATUS, 32'h0);
    // clipping on and off, both range kinds
    clipCase(32'h1, 20'sh1D4C0, acp_pkg::NOM_HI);
    clipCase(32'h1, -20'sh07530, acp_pkg::NOM_UNI_LO);
    clipCase(32'h1, 20'sh01000, 20'sh01000);
    clipCase(32'h0, 20'sh1D4C0, acp_pkg::EXT_HI);
    clipCase(32'h0, -20'sh07530, acp_pkg::EXT_UNI_LO);
    clipCase(32'h9, -20'sh1D4C0, acp_pkg::NOM_BI_LO);
    clipCase(32'h8, -20'sh1D4C0, acp_pkg::EXT_BI_LO);
    // offset add and clamp
    wr(acp_pkg::OFS_OFFSET, 32'hFFFFFFFB);
    clipCase(32'h2, 20'sh003E8, 20'sh003E3);
    wr(acp_pkg::OFS_OFFSET, 32'h00015F90);
    rd(acp_pkg::OFS_OFFSET, 32'h00014050);
    // deviation run
    clipCase(32'h0, 20'sh00BB8, 20'sh00BB8);
    wr(acp_pkg::OFS_RELAY, 32'h1);
    cyc(2);
    rd(acp_pkg::OFS_COMP, 32'h0);
    rd(acp_pkg::OFS_STATUS, 32'h40);
    cv(20'sh00DAC);
    rd(acp_pkg::OFS_COMP, 32'h1F4);
    wr(acp_pkg::OFS_RELAY, 32'h0);
    cyc(2);
    cv(20'sh00DAC);
    rd(acp_pkg::OFS_COMP, 32'hDAC);
    // point count limits
    wr(acp_pkg::OFS_TOTAL, 32'h2BC);
    rd(acp_pkg::OFS_TOTAL, 32'h258);
    wr(acp_pkg::OFS_PRE, 32'h2BC);
    rd(acp_pkg::OFS_PRE, 32'h257);
    // buffering with offset 5 applied
    wr(acp_pkg::OFS_OFFSET, 32'h5);
    wr(acp_pkg::OFS_CTRL, 32'h2);
    wr(acp_pkg::OFS_TOTAL, 32'h4);
    wr(acp_pkg::OFS_PRE, 32'h1);
    capture;
    wr(acp_pkg::OFS_RELAY, 32'h2);
    wr(acp_pkg::OFS_RELAY, 32'h6);
    cyc(2);
    chk("bufComplete", 32'h0, {31'h0, bufComplete});
    for (int i = 0; i < 4; i++) cv(20'sh00030);
    cyc(1);
    chk("bufComplete", 32'h1, {31'h0, bufComplete});
    wr(acp_pkg::OFS_RELAY, 32'h0);
    capture;
    wr(acp_pkg::OFS_BUFIDX, 32'h0);
    cyc(2);
    for (int i = 0; i < 4; i++) rd(acp_pkg::OFS_BUFDATA, (i == 0) ? 32'h10 : 32'h18 + i);
    cyc(1);
    chk("bufComplete", 32'h0, {31'h0, bufComplete});
    wr(acp_pkg::OFS_RELAY, 32'h0);
    // alarms, transient then latched
    wr(acp_pkg::OFS_CTRL, 32'h0);
    alarmCond <= 5'h03;
    cyc(3);
    chk("alarmRelay", 32'h3, {27'h0, alarmRelay});
    alarmCond <= 5'h00;
    cyc(3);
    chk("alarmRelay", 32'h0, {27'h0, alarmRelay});
    wr(acp_pkg::OFS_CTRL, 32'h4);
    alarmCond <= 5'h1F;
    cyc(3);
    alarmCond <= 5'h00;
    cyc(3);
    chk("alarmRelay", 32'h1F, {27'h0, alarmRelay});
    rd(acp_pkg::OFS_STATUS, 32'h3E);
    wr(acp_pkg::OFS_RELAY, 32'h8);
    cyc(3);
    chk("alarmRelay", 32'h0, {27'h0, alarmRelay});
    wr(acp_pkg::OFS_RELAY, 32'h0);
    // unmapped place
    ctl.wr(8'h40, 32'h1, resp);
    chk("bresp", 32'h2, {30'h0, resp});
    ctl.rd(8'h40, data, resp);
    chk("rresp", 32'h2, {30'h0, resp});
    complete_run;
  end
endmodule
`default_nettype wire
